//--- core/ctsm_defs.svh
`ifndef CTSM_DEFS_SVH
`define CTSM_DEFS_SVH

`define CTSM_CODE_W 9
`define CTSM_ID_W 7
`define CTSM_CODE_RST 9'h000
`define CTSM_DIR_BIT 0
`define CTSM_TGT_BIT 7
`define CTSM_MSB_BIT 0
`define CTSM_NVCMD_NIB 4'h9
`define CTSM_BIT_CNT_LAST 3'h7
`define CTSM_CLK_MHZ 20

`endif

//--- core/ctsm_pkg.sv
package ctsm_pkg;
  typedef enum logic [2:0] {
    CTSM_IDLE = 3'b000,
    CTSM_ADDR = 3'b001,
    CTSM_HIGH = 3'b010,
    CTSM_LOW = 3'b011,
    CTSM_IGNORE = 3'b100,
    CTSM_DONE = 3'b101
  } ctsm_state_t;

  typedef enum logic [0:0] {
    CTSM_MODE_PERSIST = 1'b0,
    CTSM_MODE_VOLATILE = 1'b1
  } ctsm_mode_t;
endpackage

//--- core/ctsm_line_if.sv
`timescale 1ns/1ns
`default_nettype none
// synchronised bus line events handed from the front end to the decoder
interface ctsm_line_if;
  logic scl_rise;
  logic scl_fall;
  logic sda_lvl;
  logic start_det;
  logic stop_det;
  modport front (output scl_rise, scl_fall, sda_lvl, start_det, stop_det);
  modport core (input scl_rise, scl_fall, sda_lvl, start_det, stop_det);
endinterface
`default_nettype wire

//--- core/ctsm_line_sync.sv
`timescale 1ns/1ns
`default_nettype none
// two-stage synchronisers and edge / start / stop detection
module ctsm_line_sync (
  input wire logic clk, // system clock
  input wire logic rst_n_s, // synchronised reset
  input wire logic scl_i, // raw clock pin
  input wire logic sda_i, // raw data pin
  ctsm_line_if.front ev // line events
);
  logic [1:0] scl_sq;
  logic [1:0] sda_sq;
  logic scl_q;
  logic sda_q;

  // ==========================================================
  // synchronisers
  always_ff @(posedge clk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      scl_sq <= 2'h3;
      sda_sq <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_sq <= {scl_sq[0], scl_i};
      sda_sq <= {sda_sq[0], sda_i};
      scl_q <= scl_sq[1];
      sda_q <= sda_sq[1];
    end
  end

  // ==========================================================
  // events
  // sample on rising clock
  assign ev.scl_rise = scl_sq[1] & ~scl_q;
  assign ev.scl_fall = ~scl_sq[1] & scl_q;
  assign ev.sda_lvl = sda_sq[1];
  // start is data falling, clock high
  assign ev.start_det = scl_sq[1] & scl_q & sda_q & ~sda_sq[1];
  assign ev.stop_det = scl_sq[1] & scl_q & ~sda_q & sda_sq[1];
endmodule
`default_nettype wire

//--- core/ctsm_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ctsm_defs.svh"
module ctsm_top #(
  parameter logic [`CTSM_ID_W-1:0] BUS_IDENTITY = 7'h2a, // arbitrary value
  parameter int CODE_W = `CTSM_CODE_W // capacitor code width
) (
  input wire logic mclk, // 20 mhz clock
  input wire logic rst_n, // power-up reset, async
  input wire logic scl_i, // serial clock pin
  input wire logic sda_i, // serial data pin level
  output logic sda_o, // data pin drive value
  output logic sda_oe, // data pin drive enable
  input wire logic [CODE_W-1:0] persistent_code_memory, // stored code
  output logic [CODE_W-1:0] capacitor_code, // code to capacitor
  output logic [CODE_W-1:0] volatile_code_reg, // volatile register
  output logic volatile_mode, // 1 = volatile mode
  output logic nv_write_req, // pulse: persistent write decoded
  output logic [7:0] nv_write_cfg_hi, // high byte of last write
  output logic [7:0] nv_write_cfg_lo, // low byte of last write
  output logic read_req // pulse: read addressed
);
  logic [1:0] rst_sq;
  logic rst_n_s;
  ctsm_line_if ev ();

  ctsm_pkg::ctsm_state_t st_q, st_d;
  ctsm_pkg::ctsm_mode_t mode_q, mode_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] hi_q, hi_d;
  logic [7:0] lo_q, lo_d;
  logic [CODE_W-1:0] vr_q, vr_d;
  logic ack_q, ack_d;
  logic ackph_q, ackph_d;
  logic nvw_q, nvw_d;
  logic rd_q, rd_d;
  logic ack_drv_q;

  // ==========================================================
  // reset release
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sq <= 2'h0;
    end else begin
      rst_sq <= {rst_sq[0], 1'b1};
    end
  end
  assign rst_n_s = rst_sq[1];

  ctsm_line_sync u_sync (
    .clk(mclk),
    .rst_n_s(rst_n_s),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ev(ev)
  );

  function automatic logic is_nv_return(input logic [7:0] b);
    is_nv_return = (b[7:4] == `CTSM_NVCMD_NIB);
  endfunction

  // ==========================================================
  // byte engine and command decode
  always_comb begin
    logic [7:0] nb;
    nb = {sh_q[6:0], ev.sda_lvl};
    st_d = st_q;
    mode_d = mode_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    hi_d = hi_q;
    lo_d = lo_q;
    vr_d = vr_q;
    ack_d = ack_q;
    ackph_d = ackph_q;
    nvw_d = 1'b0;
    rd_d = 1'b0;
    if (ev.start_det) begin
      st_d = ctsm_pkg::CTSM_ADDR;
      cnt_d = 3'h0;
      ack_d = 1'b0;
      ackph_d = 1'b0;
    end else if (ev.stop_det) begin
      st_d = ctsm_pkg::CTSM_IDLE;
      ack_d = 1'b0;
      ackph_d = 1'b0;
    end else if (ackph_q) begin
      // an acked byte keeps this phase to the fall that ends the ack bit,
      // so the ack clock's rise is never shifted in as a data bit
      if (ev.scl_fall && (ack_drv_q || !ack_q)) begin
        ack_d = 1'b0;
        ackph_d = 1'b0;
      end
    end else if (ev.scl_rise) begin
      unique case (st_q)
        ctsm_pkg::CTSM_IDLE, ctsm_pkg::CTSM_IGNORE,
        ctsm_pkg::CTSM_DONE: begin
        end
        ctsm_pkg::CTSM_ADDR, ctsm_pkg::CTSM_HIGH,
        ctsm_pkg::CTSM_LOW: begin
          sh_d = nb;
          cnt_d = cnt_q + 3'h1;
          if (cnt_q == `CTSM_BIT_CNT_LAST) begin
            ackph_d = 1'b1;
            unique case (st_q)
              ctsm_pkg::CTSM_ADDR: begin
                if (nb[7:1] == BUS_IDENTITY) begin
                  ack_d = 1'b1;
                  if (nb[`CTSM_DIR_BIT]) begin
                    rd_d = 1'b1;
                    st_d = ctsm_pkg::CTSM_DONE;
                  end else begin
                    st_d = ctsm_pkg::CTSM_HIGH;
                  end
                end else begin
                  st_d = ctsm_pkg::CTSM_IGNORE;
                end
              end
              ctsm_pkg::CTSM_HIGH: begin
                ack_d = 1'b1;
                hi_d = nb;
                st_d = ctsm_pkg::CTSM_LOW;
              end
              default: begin
                ack_d = 1'b1;
                lo_d = nb;
                st_d = ctsm_pkg::CTSM_DONE;
                if (!hi_q[`CTSM_TGT_BIT]) begin
                  vr_d = {hi_q[`CTSM_MSB_BIT], nb};
                  mode_d = ctsm_pkg::CTSM_MODE_VOLATILE;
                end else if (is_nv_return(hi_q)) begin
                  mode_d = ctsm_pkg::CTSM_MODE_PERSIST;
                end else begin
                  nvw_d = 1'b1;
                end
              end
            endcase
          end
        end
        default: st_d = ctsm_pkg::CTSM_IDLE;
      endcase
    end
  end

  // ==========================================================
  // registers
  // persistent after reset; volatile cleared
  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      st_q <= ctsm_pkg::CTSM_IDLE;
      mode_q <= ctsm_pkg::CTSM_MODE_PERSIST;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      vr_q <= `CTSM_CODE_RST;
      ack_q <= 1'b0;
      ackph_q <= 1'b0;
      nvw_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mode_q <= mode_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      vr_q <= vr_d;
      ack_q <= ack_d;
      ackph_q <= ackph_d;
      nvw_q <= nvw_d;
      rd_q <= rd_d;
    end
  end

  // ==========================================================
  // outputs
  // only data is ever driven, low only
  assign sda_o = 1'b0;
  // acknowledge waits for the falling edge so data changes with clock low
  always_ff @(posedge mclk or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ack_drv_q <= 1'b0;
    end else if (ev.start_det || ev.stop_det) begin
      ack_drv_q <= 1'b0;
    end else if (ev.scl_fall) begin
      ack_drv_q <= ackph_q & ack_q & ~ack_drv_q;
    end
  end
  assign sda_oe = ack_drv_q;
  assign capacitor_code = (mode_q == ctsm_pkg::CTSM_MODE_VOLATILE) ?
                          vr_q : persistent_code_memory;
  assign volatile_code_reg = vr_q;
  assign volatile_mode = (mode_q == ctsm_pkg::CTSM_MODE_VOLATILE);
  assign nv_write_req = nvw_q;
  assign nv_write_cfg_hi = hi_q;
  assign nv_write_cfg_lo = lo_q;
  assign read_req = rd_q;

  // ==========================================================
  // checks
  sequence s_vol_write;
    (st_q == ctsm_pkg::CTSM_LOW) && ev.scl_rise && !ackph_q &&
    !ev.start_det && !ev.stop_det && (cnt_q == 3'h7) && !hi_q[7];
  endsequence

  AST_VOL_MODE: assert property (@(posedge mclk) disable iff (!rst_n_s)
    s_vol_write |=> volatile_mode)
    else $error("volatile write did not set volatile mode");
  AST_VR_LOAD: assert property (@(posedge mclk) disable iff (!rst_n_s)
    s_vol_write |=> vr_q == {$past(hi_q[0]), $past(sh_q[6:0]),
                             $past(ev.sda_lvl)})
    else $error("volatile code not assembled");
  AST_NV_RET: assert property (@(posedge mclk) disable iff (!rst_n_s)
    ((st_q == ctsm_pkg::CTSM_LOW) && ev.scl_rise && !ackph_q &&
     !ev.start_det && !ev.stop_det && cnt_q == 3'h7 &&
     hi_q[7:4] == 4'h9) |=> !volatile_mode)
    else $error("return command kept volatile mode");
  AST_NV_KEEP: assert property (@(posedge mclk) disable iff (!rst_n_s)
    nv_write_req |-> $stable(mode_q))
    else $error("memory write changed mode");
  AST_CODE_SRC: assert property (@(posedge mclk) disable iff (!rst_n_s)
    capacitor_code == (volatile_mode ? vr_q : persistent_code_memory))
    else $error("capacitor code from wrong source");
  AST_FOREIGN: assert property (@(posedge mclk) disable iff (!rst_n_s)
    (st_q == ctsm_pkg::CTSM_IGNORE && !ev.start_det) |=>
      $stable(vr_q) && $stable(mode_q))
    else $error("foreign transfer altered state");
  AST_ACK_LOW: assert property (@(posedge mclk) disable iff (!rst_n_s)
    sda_oe |-> !sda_o)
    else $error("acknowledge not low");
  AST_ACK_HOLD: assert property (@(posedge mclk) disable iff (!rst_n_s)
    (ackph_q && ack_q && ev.scl_rise) |-> sda_oe)
    else $error("acknowledge not held across its clock");
  AST_ACK_CLK_LOW: assert property (@(posedge mclk) disable iff (!rst_n_s)
    $rose(sda_oe) |-> !ev.sda_lvl || $past(ev.scl_fall))
    else $error("acknowledge began off a falling clock");
  AST_RESET_MODE: assert property (@(posedge mclk)
    $rose(rst_n_s) |-> !volatile_mode && vr_q == 9'h000)
    else $error("reset state wrong");
endmodule
`default_nettype wire

//--- bench/ctsm_master.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// bus master model, open drain data line
module ctsm_master (
  input wire logic clk, // bench clock
  input wire logic sda_line, // resolved data line
  output var logic scl, // serial clock, stands high between frames
  output var logic sda_rel // 1 releases the data line
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  task automatic clk_bit(input logic v, output logic s);
    scl = 1'b0;
    repeat (2) @(negedge clk);
    sda_rel = v;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    repeat (4) @(negedge clk);
    s = sda_line;
  endtask
  task automatic start_c();
    sda_rel = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // data rises while clock high, no stray pulse
  task automatic stop_c();
    scl = 1'b0;
    repeat (2) @(negedge clk);
    sda_rel = 1'b0;
    repeat (2) @(negedge clk);
    scl = 1'b1;
    repeat (4) @(negedge clk);
    sda_rel = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  // bytes go most significant bit first
  task automatic byte_tx(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(b[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
endmodule
`default_nettype wire

//--- bench/ctsm_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// self-checking bench
module ctsm_top_tb;
  localparam logic [6:0] ID = 7'h35; // arbitrary value
  localparam logic [8:0] NVM = 9'h0c3;
  logic mclk, rst_n, scl, sda_rel, sda_o, sda_oe, vmode, nv_req, rd_req;
  logic [8:0] pmem, cap_code, vreg;
  logic [7:0] cfg_hi, cfg_lo;
  logic [2:0] acks;
  int failures = 0, compares = 0, cycles = 0, nv_cnt = 0, rd_cnt = 0;
  // pull-up: line is low only while someone pulls it
  wire logic sda_line = sda_rel & (sda_oe ? sda_o : 1'b1);
  ctsm_top #(.BUS_IDENTITY(ID), .CODE_W(9)) ctsm_top_inst (.mclk(mclk),
    .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe(sda_oe), .persistent_code_memory(pmem),
    .capacitor_code(cap_code), .volatile_code_reg(vreg),
    .volatile_mode(vmode), .nv_write_req(nv_req), .nv_write_cfg_hi(cfg_hi),
    .nv_write_cfg_lo(cfg_lo), .read_req(rd_req));
  ctsm_master ctsm_master_inst (.clk(mclk), .sda_line(sda_line), .scl(scl),
    .sda_rel(sda_rel));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic wrap_up();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // pulses stand one cycle, so they are counted here
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (nv_req === 1'b1) nv_cnt <= nv_cnt + 1;
    if (rd_req === 1'b1) rd_cnt <= rd_cnt + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      wrap_up();
    end
  end
  task automatic chk(input string n, input logic [8:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
  endtask
  // full selects a second config byte; stop always closes the frame
  task automatic xfer(input logic [7:0] a, h, l, input logic full);
    acks = 3'b000;
    ctsm_master_inst.start_c();
    ctsm_master_inst.byte_tx(a, acks[2]);
    ctsm_master_inst.byte_tx(h, acks[1]);
    if (full) ctsm_master_inst.byte_tx(l, acks[0]);
    ctsm_master_inst.stop_c();
  endtask
  task automatic t_power();
    chk("mode", {8'h00, vmode}, 9'h000);
    chk("vreg", vreg, 9'h000);
    chk("code", cap_code, NVM);
    chk("drive", {7'h00, sda_o, sda_oe}, 9'h000);
    $display("done power");
  endtask
  task automatic t_vol();
    xfer({ID, 1'b0}, 8'h7f, 8'ha5, 1'b1);
    chk("acks", {6'h00, acks}, 9'h007);
    chk("vreg", vreg, 9'h1a5);
    chk("mode", {8'h00, vmode}, 9'h001);
    chk("code", cap_code, 9'h1a5);
    xfer({ID, 1'b0}, 8'h00, 8'h3c, 1'b1);
    chk("vreg", vreg, 9'h03c);
    $display("done volatile");
  endtask
  task automatic t_nv();
    int n0;
    n0 = nv_cnt;
    xfer({ID, 1'b0}, 8'hc0, 8'h05, 1'b1);
    chk("nvreq", 9'(nv_cnt - n0), 9'h001);
    chk("cfghi", {1'b0, cfg_hi}, 9'h0c0);
    chk("cfglo", {1'b0, cfg_lo}, 9'h005);
    chk("mode", {8'h00, vmode}, 9'h001);
    chk("vreg", vreg, 9'h03c);
    $display("done persistent write");
  endtask
  task automatic t_ret();
    int n0;
    n0 = nv_cnt;
    xfer({ID, 1'b0}, 8'h9a, 8'h11, 1'b1);
    chk("mode", {8'h00, vmode}, 9'h000);
    chk("nvreq", 9'(nv_cnt - n0), 9'h000);
    chk("code", cap_code, NVM);
    pmem = 9'h111;
    @(negedge mclk);
    chk("code", cap_code, 9'h111);
    chk("vreg", vreg, 9'h03c);
    $display("done return");
  endtask
  task automatic t_foreign();
    xfer({ID ^ 7'h01, 1'b0}, 8'h01, 8'hff, 1'b1);
    chk("acks", {6'h00, acks}, 9'h000);
    chk("mode", {8'h00, vmode}, 9'h000);
    chk("vreg", vreg, 9'h03c);
    $display("done foreign");
  endtask
  task automatic t_read();
    int r0;
    r0 = rd_cnt;
    xfer({ID, 1'b1}, 8'h00, 8'h00, 1'b0);
    chk("acks", {6'h00, acks}, 9'h004);
    chk("rdreq", 9'(rd_cnt - r0), 9'h001);
    chk("vreg", vreg, 9'h03c);
    $display("done read");
  endtask
  task automatic t_abort();
    xfer({ID, 1'b0}, 8'h01, 8'h00, 1'b0);
    chk("acks", {6'h00, acks}, 9'h006);
    chk("mode", {8'h00, vmode}, 9'h000);
    chk("vreg", vreg, 9'h03c);
    $display("done abort");
  endtask
  task automatic t_powerloss();
    xfer({ID, 1'b0}, 8'h00, 8'h7e, 1'b1);
    chk("mode", {8'h00, vmode}, 9'h001);
    do_reset();
    chk("mode", {8'h00, vmode}, 9'h000);
    chk("vreg", vreg, 9'h000);
    $display("done power loss");
  endtask
  initial begin
    rst_n = 1'b0;
    pmem = NVM;
    do_reset();
    t_power();
    t_vol();
    t_nv();
    t_ret();
    t_foreign();
    t_read();
    t_abort();
    t_powerloss();
    wrap_up();
  end
endmodule
`default_nettype wire
